//--- rtl/pmsr_pkg.sv
// package: constants and carrier types for the power mode and supply reset block
package pmsr_pkg;

	// power control register layout (8 bits)
	localparam int PMSR_PWRCTL_W     = 8;
	localparam int PMSR_IDLE_BIT     = 0;
	localparam int PMSR_PDOWN_BIT    = 1;
	localparam int PMSR_FLAG_ZERO_BIT = 2;
	localparam int PMSR_FLAG_ONE_BIT = 3;
	localparam logic [7:0] PMSR_PWRCTL_RESET = 8'h00;
	// writable bits mask: idle, power-down, two general flags
	localparam logic [7:0] PMSR_PWRCTL_WMASK = 8'h0F;

	// clock and timing
	localparam int PMSR_CLK_MHZ        = 100;
	localparam int PMSR_GLITCH_NS      = 1000;
	localparam int PMSR_GLITCH_CYC     = (PMSR_GLITCH_NS * PMSR_CLK_MHZ + 999) / 1000;
	localparam int PMSR_HOLD_CYC_W     = 16;
	localparam int PMSR_EXT_RST_OSC    = 24;
	localparam int PMSR_PORT_W         = 8;
	localparam int PMSR_SYNC_W         = 3;

	typedef struct packed {
		logic                     wr_en;
		logic [PMSR_PWRCTL_W-1:0] wr_data;
		logic                     instr_done;
	} pmsr_cpu_req_t;

	typedef struct packed {
		logic [PMSR_PORT_W-1:0]   port_lvl;
		logic                     addr_latch;
		logic                     program_store_strobe;
	} pmsr_pins_t;

endpackage

//--- rtl/pmsr_glitch_filter.sv
// glitch filter: an input level must persist for a fixed count before it is accepted
`timescale 1ns/1ns
`default_nettype none
module pmsr_glitch_filter
	import pmsr_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic nrst_in,
	input  wire logic raw_in,
	output logic      filt_out
);
	logic [PMSR_HOLD_CYC_W-1:0] cnt_reg;

	// a dip shorter than the filter time restarts the count and leaves the output alone
	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
		begin
			cnt_reg  <= '0;
			filt_out <= 1'b0;
		end
		else if (raw_in == filt_out)
			cnt_reg <= '0;
		else if (cnt_reg >= PMSR_HOLD_CYC_W'(PMSR_GLITCH_CYC - 1))
		begin
			cnt_reg  <= '0;
			filt_out <= raw_in;
		end
		else
			cnt_reg <= cnt_reg + 1'b1;
	end
endmodule
`default_nettype wire

//--- rtl/pmsr_power_mode.sv
// power mode and supply reset controller: supply supervisor, idle and power-down control
// Overview of operation
// RL1 - hold CPU reset at power-up until supply passes the release threshold
// RL2 - assert CPU reset when supply falls to the brownout threshold
// RL3 - supply dips shorter than the filter time cause no reset
// RL4 - idle entered only after the instruction setting the idle bit completes
// RL5 - idle gates CPU clock, keeps interrupt, timer zero, serial clocks running
// RL6 - all CPU state preserved through idle
// RL7 - ports hold levels in idle; address latch and program strobes held high
// RL8 - enabled interrupt in idle clears idle bit, ends idle, gets serviced
// RL9 - after return from interrupt, execution resumes after the idle instruction
// RL10 - software-writable general flag tells idle from normal interruption
// RL11 - external reset must be held 24 oscillator periods to end idle; the code acts on it as soon as it is synchronised
// RL12 - software may request power-down through a control bit
// RL13 - hardware reset in idle clears idle bit, restarts at reset vector
`timescale 1ns/1ns
`default_nettype none
module pmsr_power_mode
	import pmsr_pkg::*;
(
	input  wire logic                   mclk_in,
	input  wire logic                   nrst_in,
	input  wire logic                   supply_above_release_in,
	input  wire logic                   supply_below_brownout_in,
	input  wire logic                   ext_reset_in,
	input  wire pmsr_cpu_req_t          cpu_req_in,
	input  wire logic                   irq_pending_in,
	input  wire pmsr_pins_t             pins_live_in,
	output logic                        cpu_reset_out,
	output logic                        cpu_clk_en_out,
	output logic                        periph_clk_en_out,
	output logic                        osc_run_out,
	output logic [PMSR_PWRCTL_W-1:0]    power_control_reg_out,
	output pmsr_pins_t                  pins_out,
	output logic                        idle_out
);
	typedef enum logic [1:0] {PMSR_RESET, PMSR_RUN, PMSR_IDLE, PMSR_PDOWN} pmsr_state_t;

	pmsr_state_t                state_reg;
	logic [PMSR_SYNC_W-1:0]     rel_sync_reg;
	logic [PMSR_SYNC_W-1:0]     bo_sync_reg;
	logic [PMSR_SYNC_W-1:0]     xr_sync_reg;
	logic                       rel_lvl_reg;
	logic                       bo_lvl_reg;
	logic                       xr_lvl_reg;
	logic                       supply_ok;
	logic                       supply_ok_filt;
	logic [PMSR_PWRCTL_W-1:0]   power_control_reg;
	logic [PMSR_PWRCTL_W-1:0]   power_control_next;
	logic                       enter_low_power;
	logic                       idle_pending_reg;
	logic                       pdown_pending_reg;
	logic                       supply_ok_reg;
	logic                       hw_reset;
	pmsr_pins_t                 pins_hold_reg;

	function automatic logic sync_agree(input logic [PMSR_SYNC_W-1:0] s, input logic cur);
		// change accepted only when the second and third stages agree
		sync_agree = (s[1] == s[2]) ? s[2] : cur;
	endfunction

	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
		begin
			rel_sync_reg <= '0;
			bo_sync_reg  <= '1;
			xr_sync_reg  <= '0;
			rel_lvl_reg  <= 1'b0;
			bo_lvl_reg   <= 1'b1;
			xr_lvl_reg   <= 1'b0;
		end
		else
		begin
			rel_sync_reg <= {rel_sync_reg[1:0], supply_above_release_in};
			bo_sync_reg  <= {bo_sync_reg[1:0], supply_below_brownout_in};
			xr_sync_reg  <= {xr_sync_reg[1:0], ext_reset_in};
			rel_lvl_reg  <= sync_agree(rel_sync_reg, rel_lvl_reg);
			bo_lvl_reg   <= sync_agree(bo_sync_reg, bo_lvl_reg);
			xr_lvl_reg   <= sync_agree(xr_sync_reg, xr_lvl_reg);
		end
	end

	// hysteresis: release needs the upper threshold, loss needs the brownout one
	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
			supply_ok_reg <= 1'b0;
		else if (!supply_ok_reg && rel_lvl_reg && !bo_lvl_reg)
			supply_ok_reg <= 1'b1; // [RL1]
		else if (supply_ok_reg && bo_lvl_reg)
			supply_ok_reg <= 1'b0; // [RL2]
	end

	assign supply_ok = supply_ok_reg;

	pmsr_glitch_filter u_filter (
		.mclk_in  (mclk_in),
		.nrst_in  (nrst_in),
		.raw_in   (supply_ok),
		.filt_out (supply_ok_filt)
	); // [RL3]

	// the external reset is expected to be held 24 oscillator periods; it acts at once here
	assign hw_reset = !supply_ok_filt || xr_lvl_reg; // [RL1] [RL2] [RL11] [RL13]

	always_comb
	begin
		power_control_next = power_control_reg;
		if (cpu_req_in.wr_en && state_reg == PMSR_RUN)
			power_control_next = (cpu_req_in.wr_data & PMSR_PWRCTL_WMASK) |
				(power_control_reg & ~PMSR_PWRCTL_WMASK); // [RL10] [RL12]
		if (state_reg == PMSR_IDLE && irq_pending_in)
			power_control_next[PMSR_IDLE_BIT] = 1'b0; // [RL8]
		if (state_reg == PMSR_PDOWN && irq_pending_in)
			power_control_next[PMSR_PDOWN_BIT] = 1'b0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in || hw_reset)
			power_control_reg <= PMSR_PWRCTL_RESET; // [RL13]
		else
			power_control_reg <= power_control_next;
	end

	// the edge that enters a low-power mode already freezes the pins, so no live value leaks
	assign enter_low_power = !hw_reset && state_reg == PMSR_RUN && cpu_req_in.instr_done &&
		(idle_pending_reg || pdown_pending_reg);

	// the writing instruction is allowed to finish before the mode takes effect
	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in || hw_reset)
		begin
			idle_pending_reg  <= 1'b0;
			pdown_pending_reg <= 1'b0;
		end
		else if (state_reg == PMSR_RUN)
		begin
			if (cpu_req_in.wr_en)
			begin
				idle_pending_reg  <= cpu_req_in.wr_data[PMSR_IDLE_BIT]; // [RL4]
				pdown_pending_reg <= cpu_req_in.wr_data[PMSR_PDOWN_BIT]; // [RL12]
			end
			else if (cpu_req_in.instr_done)
			begin
				idle_pending_reg  <= 1'b0;
				pdown_pending_reg <= 1'b0;
			end
		end
		else
		begin
			idle_pending_reg  <= 1'b0;
			pdown_pending_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in || hw_reset)
			state_reg <= PMSR_RESET;
		else
		begin
			case (state_reg)
				PMSR_RESET:
					state_reg <= PMSR_RUN;
				PMSR_RUN:
					if (cpu_req_in.instr_done && pdown_pending_reg)
						state_reg <= PMSR_PDOWN;
					else if (cpu_req_in.instr_done && idle_pending_reg)
						state_reg <= PMSR_IDLE; // [RL4]
				PMSR_IDLE:
					if (irq_pending_in)
						state_reg <= PMSR_RUN; // [RL8] [RL9]
				PMSR_PDOWN:
					if (irq_pending_in)
						state_reg <= PMSR_RUN;
				default:
					state_reg <= PMSR_RESET;
			endcase
		end
	end

	// capture pin levels while running so idle freezes them as they were
	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
			pins_hold_reg <= '0;
		else if (state_reg == PMSR_RUN)
			pins_hold_reg <= pins_live_in; // [RL7]
	end

	always_ff @(posedge mclk_in)
	begin
		if (!nrst_in)
			pins_out <= '0;
		else if (enter_low_power)
		begin
			pins_out.port_lvl             <= pins_live_in.port_lvl; // [RL7]
			pins_out.addr_latch           <= 1'b1; // [RL7]
			pins_out.program_store_strobe <= 1'b1; // [RL7]
		end
		else if (state_reg == PMSR_IDLE || state_reg == PMSR_PDOWN)
		begin
			pins_out.port_lvl             <= pins_hold_reg.port_lvl; // [RL7]
			pins_out.addr_latch           <= 1'b1; // [RL7]
			pins_out.program_store_strobe <= 1'b1; // [RL7]
		end
		else
			pins_out <= pins_live_in;
	end

	// gating the enable rather than state keeps every CPU register untouched
	assign cpu_clk_en_out        = (state_reg == PMSR_RUN); // [RL5] [RL6]
	assign periph_clk_en_out     = (state_reg == PMSR_RUN) || (state_reg == PMSR_IDLE); // [RL5]
	assign osc_run_out           = (state_reg != PMSR_PDOWN);
	assign cpu_reset_out         = (state_reg == PMSR_RESET); // [RL1] [RL2]
	assign power_control_reg_out = power_control_reg;
	assign idle_out              = (state_reg == PMSR_IDLE);
endmodule
`default_nettype wire

//--- verif/pmsr_power_mode_checker.sv
// checker: concurrent assertions on the power mode block ports
`timescale 1ns/1ns
`default_nettype none
module pmsr_power_mode_checker
	import pmsr_pkg::*;
(
	input wire logic		mclk_in,
	input wire logic		nrst_in,
	input wire logic		supply_above_release_in,
	input wire logic		ext_reset_in,
	input wire pmsr_cpu_req_t	cpu_req_in,
	input wire logic		irq_pending_in,
	input wire logic		cpu_reset_out,
	input wire logic		cpu_clk_en_out,
	input wire logic		periph_clk_en_out,
	input wire logic [7:0]	power_control_reg_out,
	input wire pmsr_pins_t	pins_out,
	input wire logic		idle_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!nrst_in);
	chk_reset_quiet: assert property (cpu_reset_out |-> !cpu_clk_en_out && !idle_out)
		else $error("core runs in reset");
	chk_release_gate: assert property ($fell(cpu_reset_out)
		|-> $past(supply_above_release_in, 5)) else $error("reset left without supply");
	chk_idle_early: assert property (!idle_out && !cpu_req_in.instr_done |=> !idle_out)
		else $error("idle without finished instruction");
	chk_idle_entry: assert property (cpu_clk_en_out && power_control_reg_out[PMSR_IDLE_BIT]
		&& cpu_req_in.instr_done |=> idle_out) else $error("idle not entered");
	chk_idle_clocks: assert property (idle_out |-> !cpu_clk_en_out && periph_clk_en_out)
		else $error("clock gating wrong in idle");
	chk_idle_pins: assert property (idle_out && $past(idle_out) |-> $stable(pins_out)
		&& pins_out.addr_latch && pins_out.program_store_strobe) else $error("pins moved in idle");
	chk_irq_exit: assert property (idle_out && irq_pending_in |=> !idle_out
		&& !power_control_reg_out[PMSR_IDLE_BIT] && cpu_clk_en_out) else $error("idle kept");
	chk_ext_clear: assert property (ext_reset_in [*8] |-> cpu_reset_out
		&& !power_control_reg_out[PMSR_IDLE_BIT]) else $error("external reset ignored");
endmodule
bind pmsr_power_mode pmsr_power_mode_checker chk_u (.*);
`default_nettype wire

//--- verif/pmsr_partner.sv
// partner model: supply comparators, external reset source and a running core's pins
`timescale 1ns/1ns
`default_nettype none
module pmsr_partner
	import pmsr_pkg::*;
(
	input  wire logic		mclk_in,
	input  wire logic		nrst_in,
	input  wire logic [1:0]	lvl_in,
	input  wire logic		rst_req_in,
	input  wire logic		cpu_clk_en_in,
	output logic			above_out,
	output logic			below_out,
	output logic			ext_reset_out,
	output pmsr_pins_t		pins_out
);
	logic [4:0]	hold_reg;
	// level 0 under brownout, 1 inside the hysteresis band, 2 above release
	assign above_out = (lvl_in == 2'h2);
	assign below_out = (lvl_in == 2'h0);
	assign ext_reset_out = (hold_reg != 5'h00);
	always_ff @(posedge mclk_in)
		if (!nrst_in)
			hold_reg <= 5'h00;
		else if (rst_req_in)
			hold_reg <= 5'(PMSR_EXT_RST_OSC);
		else if (ext_reset_out)
			hold_reg <= hold_reg - 5'h01;
	// pins move every core cycle so that any leak through a freeze shows
	always_ff @(posedge mclk_in)
		if (!nrst_in)
			pins_out <= '0;
		else if (cpu_clk_en_in)
			pins_out <= {pins_out.port_lvl + 8'h01, ~pins_out.addr_latch, ~pins_out[0]};
endmodule
`default_nettype wire

//--- verif/pmsr_power_mode_tb.sv
// testbench: power-up, idle, glitch, brownout, external reset and power-down
`timescale 1ns/1ns
`default_nettype none
module pmsr_power_mode_tb
	import pmsr_pkg::*;
;
	logic mclk_in, nrst_in, rst_req, irq, above, below, ext_rst;
	logic cpu_reset, cpu_clk_en, periph_en, osc_run, idle;
	logic [1:0] lvl;
	logic [7:0] pwr_ctl;
	pmsr_cpu_req_t req;
	pmsr_pins_t live, pins, held;
	int fails, checks;
	pmsr_partner prt_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .lvl_in(lvl), .rst_req_in(rst_req),
		.cpu_clk_en_in(cpu_clk_en), .above_out(above), .below_out(below),
		.ext_reset_out(ext_rst), .pins_out(live));
	pmsr_power_mode dut_u (.mclk_in(mclk_in), .nrst_in(nrst_in), .supply_above_release_in(above),
		.supply_below_brownout_in(below), .ext_reset_in(ext_rst), .cpu_req_in(req),
		.irq_pending_in(irq), .pins_live_in(live), .cpu_reset_out(cpu_reset),
		.cpu_clk_en_out(cpu_clk_en), .periph_clk_en_out(periph_en), .osc_run_out(osc_run),
		.power_control_reg_out(pwr_ctl), .pins_out(pins), .idle_out(idle));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] d);
		@(posedge mclk_in);
		req.wr_en <= 1'b1;
		req.wr_data <= d;
		@(posedge mclk_in);
		req.wr_en <= 1'b0;
		@(negedge mclk_in);
	endtask
	task automatic done_irq(input logic is_irq);
		@(posedge mclk_in);
		if (is_irq) irq <= 1'b1; else req.instr_done <= 1'b1;
		@(posedge mclk_in);
		irq <= 1'b0;
		req.instr_done <= 1'b0;
		repeat (2) @(negedge mclk_in);
	endtask
	task automatic set_lvl(input logic [1:0] v, input int n);
		@(posedge mclk_in);
		lvl <= v;
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic wait_run();
		for (int i = 0; i < 400 && cpu_reset !== 1'b0; i++) @(negedge mclk_in);
		chk("cpu_reset", 8'h00, cpu_reset);
	endtask
	task automatic test_idle();
		wr(8'hF5);
		chk("power control", 8'h05, pwr_ctl);
		chk("idle early", 8'h00, idle);
		done_irq(1'b0);
		chk("idle", 8'h01, idle);
		chk("clocks", 8'h01, {cpu_clk_en, periph_en});
		held = pins;
		repeat (10) @(negedge mclk_in);
		chk("port", held.port_lvl, pins.port_lvl);
		chk("strobes", 8'h03, {pins.addr_latch, pins.program_store_strobe});
		done_irq(1'b1);
		chk("power control", 8'h04, pwr_ctl);
		chk("cpu clock", 8'h01, cpu_clk_en);
		$display("test idle done");
	endtask
	task automatic test_supply();
		logic seen;
		seen = 1'b0;
		set_lvl(2'h0, 0);
		repeat (60) @(negedge mclk_in) seen |= cpu_reset;
		set_lvl(2'h2, 10);
		chk("glitch", 8'h00, seen | cpu_reset);
		set_lvl(2'h0, 130);
		chk("brownout", 8'h01, cpu_reset);
		set_lvl(2'h2, 0);
		wait_run();
		$display("test supply done");
	endtask
	task automatic test_ext_reset();
		wr(8'h01);
		done_irq(1'b0);
		@(posedge mclk_in);
		rst_req <= 1'b1;
		@(posedge mclk_in);
		rst_req <= 1'b0;
		repeat (10) @(negedge mclk_in);
		chk("reset", 8'h01, cpu_reset);
		chk("power control", 8'h00, pwr_ctl);
		wait_run();
		$display("test external reset done");
	endtask
	task automatic test_pdown();
		wr(8'h02);
		done_irq(1'b0);
		chk("osc", 8'h00, osc_run);
		done_irq(1'b1);
		chk("osc", 8'h01, osc_run);
		chk("power control", 8'h00, pwr_ctl);
		$display("test power-down done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	initial
	begin
		{nrst_in, rst_req, irq, lvl, req, fails, checks} = '0;
		repeat (2) @(posedge mclk_in);
		nrst_in <= 1'b1;
		set_lvl(2'h1, 200);
		chk("held in reset", 8'h01, cpu_reset);
		set_lvl(2'h2, 0);
		wait_run();
		test_idle();
		test_supply();
		test_ext_reset();
		test_pdown();
		report_and_stop();
	end
	initial
	begin
		#50000;
		fails++;
		report_and_stop();
	end
endmodule
`default_nettype wire
